// *** inc/eim_pkg.sv ***
// constants shared by the edge interval measure counter block
package eim_pkg;

	// ************************************************************
	// clocking and timing
	// ************************************************************
	localparam int unsigned MEAS_CLK_HZ   = 48_000_000;
	localparam int unsigned GROUP_DELAY   = 8;
	localparam int unsigned CNT_W         = 32;
	localparam int unsigned DIN_W         = 8;

	// ************************************************************
	// register offsets (byte addresses)
	// ************************************************************
	localparam logic [11:0] OFS_CTRL      = 12'h000;
	localparam logic [11:0] OFS_SEL       = 12'h004;
	localparam logic [11:0] OFS_COUNT     = 12'h008;
	localparam logic [11:0] OFS_SINGLE    = 12'h00C;
	localparam logic [11:0] OFS_STATUS    = 12'h010;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int unsigned CTRL_RUN_BIT  = 0;
	localparam int unsigned SEL_START_LSB = 0;
	localparam int unsigned SEL_STOP_LSB  = 8;
	localparam int unsigned SEL_W         = 5;
	localparam int unsigned SNG_REQ_BIT   = 0;
	localparam int unsigned SNG_DONE_BIT  = 8;
	localparam int unsigned STS_WAIT_BIT  = 0;
	localparam int unsigned STS_CNT_BIT   = 1;
	localparam int unsigned STS_HAVE_BIT  = 2;
	localparam logic [4:0]  SEL_RST       = 5'h00;
	localparam logic [7:0]  DIN_IDLE      = 8'hFF;

	// ************************************************************
	// start and stop source codes
	// ************************************************************
	localparam logic [4:0] SRC_CONV_DONE  = 5'h00;
	localparam logic [4:0] SRC_SPEED_FALL = 5'h01;
	localparam logic [4:0] SRC_SPEED_RISE = 5'h02;
	localparam logic [4:0] SRC_DIN0_FALL  = 5'h03;
	localparam logic [4:0] SRC_GCLK_FALL  = 5'h13;
	localparam logic [4:0] SRC_GATE_FALL  = 5'h15;
	localparam int unsigned SRC_LINES     = 11;
	localparam int unsigned SRC_COUNT     = 23;

	// ************************************************************
	// measurement states
	// ************************************************************
	typedef enum logic [2:0]
	{
		EIM_IDLE  = 3'h1,
		EIM_WAIT  = 3'h2,
		EIM_COUNT = 3'h4
	} eim_state_t;

endpackage

// *** inc/eim_sel_if.sv ***
// edge selection and detection link between top and edge selector
`timescale 1ns/1ps
interface eim_sel_if;
	logic [4:0] start_sel;
	logic [4:0] stop_sel;
	logic       start_hit;
	logic       stop_hit;
	logic [7:0] din_now;

	modport sel
	(
		input  start_sel,
		input  stop_sel,
		output start_hit,
		output stop_hit,
		output din_now
	);

	modport user
	(
		output start_sel,
		output stop_sel,
		input  start_hit,
		input  stop_hit,
		input  din_now
	);
endinterface

// *** design/eim_edge_sel.sv ***
// edge detector and start/stop source selector
`timescale 1ns/1ps
module eim_edge_sel
(
	// clock and reset
	input  wire logic   mclk,
	input  wire logic   rst_n,
	// raw event lines
	input  wire logic   conv_done,
	input  wire logic   speed_pulse_input,
	input  wire logic [7:0] din,
	input  wire logic   gp_clk_in,
	input  wire logic   gp_gate_in,
	// selection link
	eim_sel_if.sel      link
);

	typedef struct packed
	{
		logic [eim_pkg::SRC_LINES-1:0] prev;
		logic [7:0]                    din_q;
	} eim_edge_t;

	eim_edge_t cur;
	eim_edge_t next_cur;
	logic [eim_pkg::SRC_LINES-1:0] lines;
	logic [31:0]                   ev;

	assign lines = {gp_gate_in, gp_clk_in, din, speed_pulse_input};

	// ************************************************************
	// event vector: conversion done, then fall/rise per line
	// ************************************************************
	assign ev[0] = conv_done;
	genvar i;
	generate
		for (i = 0; i < eim_pkg::SRC_LINES; i++)
		begin : g_ev
			assign ev[1 + 2*i] = cur.prev[i] & ~lines[i];
			assign ev[2 + 2*i] = ~cur.prev[i] & lines[i];
		end
	endgenerate
	assign ev[31:eim_pkg::SRC_COUNT] = '0;

	// codes past the list select nothing
	assign link.start_hit = ev[link.start_sel];
	assign link.stop_hit  = ev[link.stop_sel];
	assign link.din_now   = cur.din_q;

	// history of lines; idle-high so a floating port gives no edge
	always_comb
	begin
		next_cur       = cur;
		next_cur.prev  = lines;
		next_cur.din_q = din;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur.prev  <= '1;
			cur.din_q <= eim_pkg::DIN_IDLE;
		end
		else
		begin
			cur <= next_cur;
		end
	end

endmodule

// *** design/eim_delay.sv ***
// fixed-depth pipeline that aligns samples with the converter delay
`timescale 1ns/1ps
module eim_delay
#(
	parameter int unsigned W     = 40,
	parameter int unsigned DEPTH = 8
)
(
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst_n,
	// sample in
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	// sample out
	output logic              out_valid,
	output logic [W-1:0]      out_data
);

	generate
		if (DEPTH < 1 || W < 1)
		begin : g_bad
			$error("eim_delay needs DEPTH and W of at least one");
		end
	endgenerate

	typedef struct packed
	{
		logic [DEPTH-1:0]      vld;
		logic [DEPTH-1:0][W-1:0] dat;
	} eim_pipe_t;

	eim_pipe_t cur;
	eim_pipe_t next_cur;

	// shift one stage per clock; entry 0 takes the new sample
	always_comb
	begin
		next_cur = cur;
		next_cur.vld[0] = in_valid;
		next_cur.dat[0] = in_data;
		for (int k = 1; k < DEPTH; k++)
		begin
			next_cur.vld[k] = cur.vld[k-1];
			next_cur.dat[k] = cur.dat[k-1];
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur <= '0;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	assign out_valid = cur.vld[DEPTH-1];
	assign out_data  = cur.dat[DEPTH-1];

endmodule

// *** design/eim_top.sv ***
// edge interval measure counter with digital input port, APB slave
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module eim_top
#(
	parameter int unsigned CNT_W       = eim_pkg::CNT_W,
	parameter int unsigned GROUP_DELAY = eim_pkg::GROUP_DELAY
)
(
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         nrst,
	// apb slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// event sources
	input  wire logic         conv_done,
	input  wire logic         speed_pulse_input,
	input  wire logic [7:0]   din,
	input  wire logic         gp_clk_in,
	input  wire logic         gp_gate_in,
	// acquisition sample clock tick
	input  wire logic         sample_tick,
	// aligned stream out
	output logic              stream_valid,
	output logic [CNT_W-1:0]  stream_count,
	output logic [7:0]        stream_din
);

	// ************************************************************
	// parameter checks
	// ************************************************************
	generate
		if (CNT_W < 2 || CNT_W > 32 || GROUP_DELAY < 1)
		begin : g_bad
			$error("eim_top needs CNT_W 2..32 and GROUP_DELAY >= 1");
		end
	endgenerate

	localparam int unsigned SW = CNT_W + eim_pkg::DIN_W;

	// ************************************************************
	// reset release
	// ************************************************************
	logic [1:0] rst_sync;
	logic       rst_n;

	// async assert, two-flop release
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_sync <= 2'h0;
		end
		else
		begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// ************************************************************
	// block state
	// ************************************************************
	typedef struct packed
	{
		logic                  run;
		logic                  run_d;
		logic [4:0]            start_sel;
		logic [4:0]            stop_sel;
		eim_pkg::eim_state_t   st;
		logic [CNT_W-1:0]      cnt;
		logic [CNT_W-1:0]      latched;
		logic                  have;
		logic [7:0]            single_val;
		logic                  single_done;
		logic [31:0]           rdata;
		logic                  err;
	} eim_top_t;

	eim_top_t   cur;
	eim_top_t   next_cur;
	eim_sel_if  sel_link ();

	logic             setup;
	logic             wr_access;
	logic             mapped;
	logic             op_start;
	logic             same_edge;
	logic [CNT_W-1:0] cnt_inc;
	logic             smp_valid;
	logic [SW-1:0]    smp_data;
	logic [SW-1:0]    out_data;

	// ************************************************************
	// edge selection and detection
	// ************************************************************
	assign sel_link.start_sel = cur.start_sel;
	assign sel_link.stop_sel  = cur.stop_sel;

	eim_edge_sel u_edge
	(
		.mclk              (mclk),
		.rst_n             (rst_n),
		.conv_done         (conv_done),
		.speed_pulse_input (speed_pulse_input),
		.din               (din),
		.gp_clk_in         (gp_clk_in),
		.gp_gate_in        (gp_gate_in),
		.link              (sel_link)
	);

	// ************************************************************
	// bus decode
	// ************************************************************
	assign setup     = psel & ~penable;
	assign wr_access = psel & penable & pwrite;
	assign mapped    = (paddr == eim_pkg::OFS_CTRL)   |
	                   (paddr == eim_pkg::OFS_SEL)    |
	                   (paddr == eim_pkg::OFS_COUNT)  |
	                   (paddr == eim_pkg::OFS_SINGLE) |
	                   (paddr == eim_pkg::OFS_STATUS);

	// zero wait states: read data captured in setup is ready in the access phase
	assign pready  = 1'b1;
	assign prdata  = cur.rdata;
	assign pslverr = psel & penable & cur.err;

	assign op_start  = cur.run & ~cur.run_d;
	assign same_edge = cur.start_sel == cur.stop_sel;
	// saturate rather than wrap on a stuck input
	assign cnt_inc   = (&cur.cnt) ? cur.cnt : cur.cnt + 1'b1;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb
	begin
		next_cur       = cur;
		next_cur.run_d = cur.run;

		// register writes take effect in the access phase
		if (wr_access && paddr == eim_pkg::OFS_CTRL)
		begin
			next_cur.run = pwdata[eim_pkg::CTRL_RUN_BIT];
		end
		if (wr_access && paddr == eim_pkg::OFS_SEL)
		begin
			next_cur.start_sel =
				pwdata[eim_pkg::SEL_START_LSB +: eim_pkg::SEL_W];
			next_cur.stop_sel  =
				pwdata[eim_pkg::SEL_STOP_LSB +: eim_pkg::SEL_W];
		end

		// single read: one sample of all eight port lines, no abort path
		if (wr_access && paddr == eim_pkg::OFS_SINGLE &&
			pwdata[eim_pkg::SNG_REQ_BIT])
		begin
			next_cur.single_val  = sel_link.din_now;
			next_cur.single_done = 1'b1;
		end

		// measurement sequence
		case (cur.st)
			eim_pkg::EIM_IDLE:
			begin
				next_cur.cnt = '0;
			end
			eim_pkg::EIM_WAIT:
			begin
				if (sel_link.start_hit)
				begin
					next_cur.cnt = {{(CNT_W-1){1'b0}}, 1'b1};
					next_cur.st  = eim_pkg::EIM_COUNT;
				end
			end
			eim_pkg::EIM_COUNT:
			begin
				next_cur.cnt = cnt_inc;
				if (sel_link.stop_hit)
				begin
					// this edge is one more period: report periods + 1
					next_cur.latched = cnt_inc;
					next_cur.have    = 1'b1;
					if (same_edge)
					begin
						// stop doubles as the next start
						next_cur.cnt = {{(CNT_W-1){1'b0}}, 1'b1};
					end
					else
					begin
						next_cur.cnt = '0;
						next_cur.st  = eim_pkg::EIM_WAIT;
					end
				end
			end
			default:
			begin
				next_cur.st = eim_pkg::EIM_IDLE;
			end
		endcase

		// a new operation wipes old results first
		if (op_start)
		begin
			next_cur.cnt     = '0;
			next_cur.latched = '0;
			next_cur.have    = 1'b0;
			next_cur.st      = eim_pkg::EIM_WAIT;
		end
		if (!cur.run)
		begin
			next_cur.st = eim_pkg::EIM_IDLE;
		end

		// read data captured in setup so it is a flop in access
		next_cur.err = setup & ~mapped;
		if (setup)
		begin
			next_cur.rdata = 32'h0000_0000;
			case (paddr)
				eim_pkg::OFS_CTRL:
					next_cur.rdata[eim_pkg::CTRL_RUN_BIT] = cur.run;
				eim_pkg::OFS_SEL:
				begin
					next_cur.rdata[eim_pkg::SEL_START_LSB +:
						eim_pkg::SEL_W] = cur.start_sel;
					next_cur.rdata[eim_pkg::SEL_STOP_LSB +:
						eim_pkg::SEL_W] = cur.stop_sel;
				end
				eim_pkg::OFS_COUNT:
					next_cur.rdata[CNT_W-1:0] = cur.latched;
				eim_pkg::OFS_SINGLE:
				begin
					next_cur.rdata[7:0] = cur.single_val;
					next_cur.rdata[eim_pkg::SNG_DONE_BIT] =
						cur.single_done;
				end
				eim_pkg::OFS_STATUS:
				begin
					next_cur.rdata[eim_pkg::STS_WAIT_BIT] =
						cur.st == eim_pkg::EIM_WAIT;
					next_cur.rdata[eim_pkg::STS_CNT_BIT] =
						cur.st == eim_pkg::EIM_COUNT;
					next_cur.rdata[eim_pkg::STS_HAVE_BIT] = cur.have;
				end
				default:
					next_cur.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur.run         <= 1'b0;
			cur.run_d       <= 1'b0;
			cur.start_sel   <= eim_pkg::SEL_RST;
			cur.stop_sel    <= eim_pkg::SEL_RST;
			cur.st          <= eim_pkg::EIM_IDLE;
			cur.cnt         <= '0;
			cur.latched     <= '0;
			cur.have        <= 1'b0;
			cur.single_val  <= eim_pkg::DIN_IDLE;
			cur.single_done <= 1'b0;
			cur.rdata       <= 32'h0000_0000;
			cur.err         <= 1'b0;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	// ************************************************************
	// sample capture and group-delay alignment
	// ************************************************************
	// sampling never disturbs the latched value, so repeats are free
	assign smp_valid = sample_tick & cur.run;
	assign smp_data  = {cur.latched, sel_link.din_now};

	eim_delay
	#(
		.W     (SW),
		.DEPTH (GROUP_DELAY)
	)
	u_delay
	(
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_valid  (smp_valid),
		.in_data   (smp_data),
		.out_valid (stream_valid),
		.out_data  (out_data)
	);

	assign stream_count = out_data[SW-1:eim_pkg::DIN_W];
	assign stream_din   = out_data[eim_pkg::DIN_W-1:0];

endmodule

// *** dv/eim_props.sv ***
// assertions on the ports of the measure counter top module
`timescale 1ns/1ps
module eim_props
#(
	parameter int unsigned GROUP_DELAY = 8
)
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        nrst,
	// register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// port and stream
	input wire logic [7:0]  din,
	input wire logic        sample_tick,
	input wire logic        stream_valid,
	input wire logic [7:0]  stream_din
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	// ****************
	// bus answers
	// ****************
	ready_in_access_a: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	err_in_access_a: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	err_data_zero_a: assert property (pslverr |-> prdata == 32'h0)
		else $error("refused access returned data");
	mapped_no_err_a: assert property (psel && penable
		&& paddr <= 12'h010 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	// read data may only move at the edge that ends a setup cycle
	rdata_from_setup_a: assert property
		($changed(prdata) |-> $past(psel && !penable))
		else $error("prdata moved outside setup");

	// ****************
	// stream timing
	// ****************
	tick_gives_word_a: assert property
		($past(sample_tick, GROUP_DELAY) |-> stream_valid)
		else $error("sample tick produced no word");
	word_has_tick_a: assert property
		(stream_valid |-> $past(sample_tick, GROUP_DELAY))
		else $error("stream word without sample tick");
	din_aligned_a: assert property (stream_valid
		|-> stream_din == $past(din, GROUP_DELAY + 1))
		else $error("port byte not aligned with sample");
endmodule

bind eim_top eim_props #(.GROUP_DELAY(GROUP_DELAY)) u_props
(
	.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.din(din), .sample_tick(sample_tick), .stream_valid(stream_valid),
	.stream_din(stream_din)
);

// *** dv/eim_smp.sv ***
// acquisition sampler model: paces samples and keeps stream words
`timescale 1ns/1ps
module eim_smp
(
	// clock
	input wire logic        mclk,
	// pacing set by the bench
	input wire logic        en,
	input wire logic [15:0] period,
	// stream from the block
	input wire logic        stream_valid,
	input wire logic [31:0] stream_count,
	input wire logic [7:0]  stream_din,
	// pacing out, newest word kept
	output logic            sample_tick = 1'b0,
	output logic [31:0]     last_count = 32'hFFFF_FFFF, // not zero: no word shows
	output logic [7:0]      last_din = 8'h0,
	output int              seen = 0
);
	logic [15:0] cnt = 16'h0;

	// one tick per period; stops at once when disabled
	always @(posedge mclk)
	begin
		cnt <= (en && cnt + 16'h1 < period) ? cnt + 16'h1 : 16'h0;
		sample_tick <= en && cnt == period - 16'h1;
	end

	// newest word wins, like a channel-list slot
	always @(posedge mclk)
		if (stream_valid === 1'b1)
		begin
			last_count <= stream_count;
			last_din <= stream_din;
			seen <= seen + 1;
		end
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the measure counter block
`timescale 1ns/1ps
module tb_top;
	localparam int unsigned GD = 2;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        spd = 1'b0;
	logic        cdone = 1'b0;
	logic        gck = 1'b0;
	logic        gte = 1'b0;
	logic [7:0]  din = 8'hFF;
	logic        tick;
	logic        sv;
	logic [31:0] scnt;
	logic [7:0]  sdin;
	logic        en = 1'b0;
	logic [15:0] per = 16'h4;
	logic [31:0] lc;
	logic [7:0]  ld;
	logic [31:0] q;
	logic        e;
	int          seen;
	int          s0;
	int          errors = 0;
	int          comparisons = 0;

	// short pipeline keeps the run brief
	eim_top #(.GROUP_DELAY(GD)) dut
	(
		.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.conv_done(cdone), .speed_pulse_input(spd), .din(din),
		.gp_clk_in(gck), .gp_gate_in(gte), .sample_tick(tick),
		.stream_valid(sv), .stream_count(scnt), .stream_din(sdin)
	);

	eim_smp smp
	(
		.mclk(mclk), .en(en), .period(per), .stream_valid(sv),
		.stream_count(scnt), .stream_din(sdin), .sample_tick(tick),
		.last_count(lc), .last_din(ld), .seen(seen)
	);

	// 40 MHz clock
	always #12.5 mclk = ~mclk;

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask

	// one bus transfer; waits for pready, never assumes it
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 100);
		errors += (n >= 100);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask

	// stop, pick edges, restart the operation
	task automatic cfg(input logic [4:0] s, input logic [4:0] p);
		apb(1'b1, eim_pkg::OFS_CTRL, 32'h0);
		apb(1'b1, eim_pkg::OFS_SEL, {19'h0, p, 3'h0, s});
		apb(1'b1, eim_pkg::OFS_CTRL, 32'h1);
		cyc(4);
	endtask

	task automatic spul(input int hi, input int lo);
		spd <= 1'b1;
		cyc(hi);
		spd <= 1'b0;
		cyc(lo);
	endtask

	task automatic give_verdict;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// main sequence
	initial
	begin
		cyc(4);
		nrst <= 1'b1;
		cyc(3);
		rd(eim_pkg::OFS_CTRL, 32'h0);
		rd(eim_pkg::OFS_SEL, 32'h0);
		rd(eim_pkg::OFS_COUNT, 32'h0);
		rd(eim_pkg::OFS_SINGLE, 32'hFF);
		apb(1'b0, 12'h014, 32'h0);
		chk({31'h0, e}, 32'h1);
		din <= 8'hA5;
		apb(1'b1, eim_pkg::OFS_SINGLE, 32'h1);
		din <= 8'hFF;
		rd(eim_pkg::OFS_SINGLE, 32'h1A5);
		// distinct edges: high time of 10 gives 11
		cfg(eim_pkg::SRC_SPEED_RISE, eim_pkg::SRC_SPEED_FALL);
		rd(eim_pkg::OFS_STATUS, 32'h1);
		spul(10, 4);
		rd(eim_pkg::OFS_COUNT, 32'd11);
		rd(eim_pkg::OFS_COUNT, 32'd11);
		rd(eim_pkg::OFS_STATUS, 32'h5);
		spul(6, 4);
		rd(eim_pkg::OFS_COUNT, 32'd7);
		// equal edges: each rise also opens the next interval
		cfg(eim_pkg::SRC_SPEED_RISE, eim_pkg::SRC_SPEED_RISE);
		rd(eim_pkg::OFS_COUNT, 32'h0);
		spul(5, 7);
		spul(8, 12);
		spul(4, 4);
		rd(eim_pkg::OFS_COUNT, 32'd21);
		// every port line as source, low time differs per line
		for (int n = 0; n < 8; n++)
		begin
			cfg(eim_pkg::SRC_DIN0_FALL + 5'(2 * n),
				eim_pkg::SRC_DIN0_FALL + 5'(2 * n + 1));
			din[n] <= 1'b0;
			cyc(n + 3);
			din[n] <= 1'b1;
			cyc(3);
			rd(eim_pkg::OFS_COUNT, 32'(n + 4));
		end
		// conversion done starts at once, general clock rise stops
		cfg(eim_pkg::SRC_CONV_DONE, eim_pkg::SRC_GCLK_FALL + 5'h1);
		cdone <= 1'b1;
		cyc(1);
		cdone <= 1'b0;
		cyc(5);
		gck <= 1'b1;
		cyc(3);
		rd(eim_pkg::OFS_COUNT, 32'd7);
		// general clock fall starts, gate rise stops
		cfg(eim_pkg::SRC_GCLK_FALL, eim_pkg::SRC_GATE_FALL + 5'h1);
		gck <= 1'b0;
		cyc(4);
		gte <= 1'b1;
		cyc(3);
		rd(eim_pkg::OFS_COUNT, 32'd5);
		// a code past the list never opens a measurement
		cfg(5'h17, eim_pkg::SRC_SPEED_FALL);
		spul(3, 3);
		rd(eim_pkg::OFS_STATUS, 32'h1);
		// fast sampling: zero first, then the retained value
		cfg(eim_pkg::SRC_SPEED_RISE, eim_pkg::SRC_SPEED_FALL);
		din <= 8'h3C;
		per <= 16'd5;
		en <= 1'b1;
		cyc(20);
		chk(lc, 32'h0);
		spul(30, 10);
		s0 = seen;
		cyc(20);
		chk(lc, 32'd31);
		chk(32'(seen - s0), 32'd4);
		chk({24'h0, ld}, 32'h3C);
		en <= 1'b0;
		cyc(8);
		// slow sampling: only the newest of many counts
		cfg(eim_pkg::SRC_SPEED_RISE, eim_pkg::SRC_SPEED_RISE);
		per <= 16'd40;
		en <= 1'b1;
		repeat (30) spul(3, 3);
		chk(lc, 32'd7);
		// shorter period: the newer count must replace the older one
		repeat (10) spul(2, 3);
		cyc(4);
		chk(lc, 32'd6);
		en <= 1'b0;
		cyc(8);
		give_verdict;
	end

	// watchdog, far beyond the expected run length
	initial
	begin
		cyc(20000);
		errors++;
		give_verdict;
	end
endmodule
